//--- rtl/adspi_link.sv
`timescale 1ns/10ps
module adspi_link
    import adspi_pkg::*;
(
    input wire logic sclk,
    input wire logic rst_b,
    input wire logic frame_select_n,
    input wire logic serial_in,
    input wire logic [15:0] statusWord0,
    input wire logic [15:0] statusWord1,
    input wire logic faultFree,
    output logic linkBit,
    output adspi_pkg::adspi_frame_t frameOut,
    output logic frameTog_r
);
    import adspi_pkg::*;

    logic startTog_r;
    logic inTag_r;
    logic outTag_r;
    logic [4:0] bitCount_r;
    logic [15:0] shiftIn_r;
    logic [15:0] loadWord_r;
    logic [3:0] outIdx_r;
    logic seenEdge;

    // ------------------------------------------------------------
    // frame start marker
    // ------------------------------------------------------------
    // a toggle per frame start avoids racing an async clear against the end capture
    always_ff @(negedge frame_select_n or negedge rst_b) begin
        if (!rst_b) begin
            startTog_r <= 1'b0;
        end else if (seenEdge) begin
            // a frame with no clock keeps the marker pending, so a poll cannot alias the next one
            startTog_r <= ~startTog_r;
        end
    end

    assign seenEdge = (inTag_r == startTog_r);

    // ------------------------------------------------------------
    // receive side, rising edges
    // ------------------------------------------------------------
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            shiftIn_r <= 16'h0000;
            bitCount_r <= 5'h00;
            inTag_r <= 1'b0;
            loadWord_r <= 16'h0000;
        end else begin
            shiftIn_r <= {serial_in, shiftIn_r[15:1]};
            if (!seenEdge) begin
                inTag_r <= startTog_r;
                bitCount_r <= 5'h01;
                loadWord_r <= serial_in ? statusWord1 : statusWord0;
            end else if (bitCount_r != 5'h1f) begin
                bitCount_r <= bitCount_r + 5'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // transmit side, falling edges
    // ------------------------------------------------------------
    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            outTag_r <= 1'b0;
            outIdx_r <= 4'h0;
        end else if (outTag_r != startTog_r) begin
            outTag_r <= startTog_r;
            outIdx_r <= 4'h1;
        end else begin
            outIdx_r <= outIdx_r + 4'h1;
        end
    end

    // before the first clock the pin shows the summary bit
    always_comb begin
        if (!seenEdge) begin
            linkBit = faultFree;
        end else if (outTag_r != startTog_r) begin
            linkBit = loadWord_r[0];
        end else begin
            linkBit = loadWord_r[outIdx_r];
        end
    end

    // ------------------------------------------------------------
    // frame end capture
    // ------------------------------------------------------------
    always_ff @(posedge frame_select_n or negedge rst_b) begin
        if (!rst_b) begin
            frameOut <= '0;
            frameTog_r <= 1'b0;
        end else begin
            frameOut.word <= shiftIn_r;
            frameOut.valid <= seenEdge && (bitCount_r == 5'(FRAME_BITS));
            frameTog_r <= ~frameTog_r;
        end
    end
endmodule // adspi_link

//--- rtl/adspi_pkg.sv
package adspi_pkg;

    // ------------------------------------------------------------
    // frame and command word layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int CMD_SEL_BIT = 0;
    localparam int CMD_DRV_LO = 1;
    localparam int CMD_MON_LO = 9;
    localparam int CMD_MON_HI = 11;
    localparam int CMD_SUPPLY_LATCH = 12;
    localparam int CMD_DUTY_HIGH = 13;
    localparam int CMD_OPENLOAD_IGNORE = 14;
    localparam int CMD_STATUS_CLEAR = 15;
    localparam int CMD1_RECOVERY_LO = 1;
    localparam int CMD1_PWM_EN_LO = 9;
    localparam logic [15:0] CMD_RESET = 16'h0000;

    // ------------------------------------------------------------
    // fault report word layout
    // ------------------------------------------------------------
    localparam int ST_FAULT_FREE = 0;
    localparam int ST_OC_LO = 1;
    localparam int ST_OL_LO = 1;
    localparam int ST_NOT_READY = 10;
    localparam int ST_TEMP_WARN = 11;
    localparam int ST_OVERTEMP = 12;
    localparam int ST_UNDER_VOLT = 13;
    localparam int ST_OVER_VOLT = 14;
    localparam int ST_ALWAYS_ONE = 15;

    // ------------------------------------------------------------
    // drivers and timing
    // ------------------------------------------------------------
    localparam int NUM_DRV = 8;
    localparam int NUM_OUT = 5;
    localparam int NUM_BRIDGE = 3;
    localparam int CLK_MHZ = 20;
    localparam int SETTLE_US = 200;
    localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
    localparam int DUTY_PERIOD_US = 100;
    localparam int DUTY_PERIOD_CYCLES = DUTY_PERIOD_US * CLK_MHZ;
    localparam int DUTY_LOW_PCT = 12;
    localparam int DUTY_HIGH_PCT = 25;
    localparam int DUTY_LOW_CYCLES = DUTY_PERIOD_CYCLES * DUTY_LOW_PCT / 100;
    localparam int DUTY_HIGH_CYCLES = DUTY_PERIOD_CYCLES * DUTY_HIGH_PCT / 100;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_DRV-1:0] overCurrent;
        logic [NUM_DRV-1:0] openLoad;
        logic overVolt;
        logic underVolt;
        logic overTemp;
        logic tempWarn;
    } adspi_events_t;

    typedef struct packed {
        logic valid;
        logic [FRAME_BITS-1:0] word;
    } adspi_frame_t;

endpackage

//--- rtl/adspi_sync2.sv
`timescale 1ns/10ps
module adspi_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_r <= '0;
            syncOut <= '0;
        end else begin
            stage1_r <= asyncIn;
            syncOut <= stage1_r;
        end
    end
endmodule // adspi_sync2

//--- rtl/adspi_top.sv
`timescale 1ns/10ps
module adspi_top
    import adspi_pkg::*;
#(
    parameter int SETTLE_CNT = SETTLE_CYCLES,
    parameter int DUTY_PERIOD = DUTY_PERIOD_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic frame_select_n,
    input wire logic serial_in,
    output logic serialOut,
    output logic serialOutEn,
    input wire logic testModeDetect,
    input wire logic enableIn,
    input wire logic pwmIn,
    input wire logic intOsc,
    input wire adspi_pkg::adspi_events_t eventsIn,
    output logic [adspi_pkg::NUM_DRV-1:0] driverOn_r,
    output logic [2:0] monitorSel_r,
    output logic recoveryDuty25_r,
    output logic ocThresholdLow_r,
    output logic testModeActive
);
    import adspi_pkg::*;

    if (SETTLE_CNT < 1 || SETTLE_CNT > 65535
        || DUTY_PERIOD < 8 || DUTY_PERIOD > 65535) begin : g_param_check
        $error("adspi_top: timer parameter out of range");
    end

    localparam int SYNC_W = $bits(adspi_events_t) + 5;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    adspi_events_t evS;
    adspi_frame_t frameLink;
    logic [SYNC_W-1:0] syncIn;
    logic [SYNC_W-1:0] syncOut;
    logic pwmS;
    logic testS;
    logic enS;
    logic csnS;
    logic frameTogS;
    logic frameTogLink;
    logic frameTogD_r;
    logic applyFrame;
    logic statusClear;
    logic [15:0] cmd0_r;
    logic [15:0] cmd1_r;
    logic [NUM_DRV-1:0] ocFlag_r;
    logic [NUM_DRV-1:0] olFlag_r;
    logic ovFlag_r;
    logic uvFlag_r;
    logic tsdFlag_r;
    logic twFlag_r;
    logic notReady_r;
    logic enD_r;
    logic [15:0] settleCnt_r;
    logic [15:0] dutyCnt_r;
    logic dutyOn;
    logic faultFree;
    logic [15:0] status0;
    logic [15:0] status1;
    logic [15:0] snap0_r;
    logic [15:0] snap1_r;
    logic supplyBlock;
    logic [NUM_DRV-1:0] drvReq;
    logic [NUM_DRV-1:0] drvAllow;
    logic [NUM_DRV-1:0] drvOn_nxt;
    logic [NUM_BRIDGE-1:0] bridgeBoth;
    logic linkBit;
    logic testBit;

    // maps a driver to the output it belongs to
    function automatic int outOfDrv(input int drv);
        if (drv < 2 * NUM_BRIDGE) begin
            return drv / 2;
        end
        return drv - NUM_BRIDGE;
    endfunction

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    assign syncIn = {eventsIn, pwmIn, testModeDetect, enableIn, frame_select_n, frameTogLink};

    adspi_sync2 #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(syncIn),
        .syncOut(syncOut)
    );

    assign {evS, pwmS, testS, enS, csnS, frameTogS} = syncOut;
    assign testModeActive = testS;

    // ------------------------------------------------------------
    // serial link on the serial clock
    // ------------------------------------------------------------
    adspi_link u_link (
        .sclk(sclk),
        .rst_b(rst_b),
        .frame_select_n(frame_select_n),
        .serial_in(serial_in),
        .statusWord0(snap0_r),
        .statusWord1(snap1_r),
        .faultFree(faultFree),
        .linkBit(linkBit),
        .frameOut(frameLink),
        .frameTog_r(frameTogLink)
    );

    // ------------------------------------------------------------
    // frame hand-over
    // ------------------------------------------------------------
    // captured word stays put for a whole frame, so it is read after the toggle lands
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            frameTogD_r <= 1'b0;
        end else begin
            frameTogD_r <= frameTogS;
        end
    end

    assign applyFrame = (frameTogS ^ frameTogD_r) & frameLink.valid;
    assign statusClear = applyFrame & frameLink.word[CMD_STATUS_CLEAR];

    // ------------------------------------------------------------
    // command words
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd0_r <= CMD_RESET;
            cmd1_r <= CMD_RESET;
        end else if (applyFrame) begin
            if (frameLink.word[CMD_SEL_BIT]) begin
                cmd1_r <= frameLink.word;
            end else begin
                cmd0_r <= frameLink.word;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            monitorSel_r <= 3'h0;
        end else begin
            monitorSel_r <= cmd0_r[CMD_MON_HI:CMD_MON_LO];
        end
    end

    // ------------------------------------------------------------
    // sticky status flags
    // ------------------------------------------------------------
    // a live event reasserts over a clear so nothing is lost
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ocFlag_r <= '0;
            olFlag_r <= '0;
            ovFlag_r <= 1'b0;
            uvFlag_r <= 1'b0;
            tsdFlag_r <= 1'b0;
            twFlag_r <= 1'b0;
        end else begin
            ocFlag_r <= evS.overCurrent | (ocFlag_r & {NUM_DRV{~statusClear}});
            olFlag_r <= evS.openLoad | (olFlag_r & {NUM_DRV{~statusClear}});
            ovFlag_r <= evS.overVolt | (ovFlag_r & ~statusClear);
            uvFlag_r <= evS.underVolt | (uvFlag_r & ~statusClear);
            tsdFlag_r <= evS.overTemp | (tsdFlag_r & ~statusClear);
            twFlag_r <= evS.tempWarn | (twFlag_r & ~statusClear);
        end
    end

    // ------------------------------------------------------------
    // standby exit settle timer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enD_r <= 1'b0;
            notReady_r <= 1'b0;
            settleCnt_r <= 16'h0000;
        end else begin
            enD_r <= enS;
            if (enS && !enD_r) begin
                notReady_r <= 1'b1;
                settleCnt_r <= 16'(SETTLE_CNT - 1);
            end else if (settleCnt_r != 16'h0000) begin
                settleCnt_r <= settleCnt_r - 16'h0001;
            end else begin
                notReady_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // report words and summary
    // ------------------------------------------------------------
    always_comb begin
        faultFree = ~(|ocFlag_r | ovFlag_r | uvFlag_r | tsdFlag_r | twFlag_r | notReady_r
            | (|olFlag_r & ~cmd0_r[CMD_OPENLOAD_IGNORE]));
        status0 = 16'h0000;
        status0[ST_ALWAYS_ONE] = 1'b1;
        status0[ST_OVER_VOLT] = ovFlag_r;
        status0[ST_UNDER_VOLT] = uvFlag_r;
        status0[ST_OVERTEMP] = tsdFlag_r;
        status0[ST_TEMP_WARN] = twFlag_r;
        status0[ST_NOT_READY] = notReady_r;
        status0[ST_OC_LO +: NUM_DRV] = ocFlag_r;
        status0[ST_FAULT_FREE] = faultFree;
        status1 = 16'h0000;
        status1[ST_ALWAYS_ONE] = 1'b1;
        status1[ST_OL_LO +: NUM_DRV] = olFlag_r;
        status1[ST_FAULT_FREE] = faultFree;
    end

    // snapshot frozen while a frame runs, so the link reads a steady word
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            snap0_r <= 16'h8001;
            snap1_r <= 16'h8001;
        end else if (csnS) begin
            snap0_r <= status0;
            snap1_r <= status1;
        end
    end

    // ------------------------------------------------------------
    // over-current recovery duty
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dutyCnt_r <= 16'h0000;
            recoveryDuty25_r <= 1'b0;
            ocThresholdLow_r <= 1'b0;
        end else begin
            dutyCnt_r <= (dutyCnt_r == 16'(DUTY_PERIOD - 1)) ? 16'h0000 : dutyCnt_r + 16'h0001;
            recoveryDuty25_r <= cmd0_r[CMD_DUTY_HIGH] & ~twFlag_r;
            ocThresholdLow_r <= testS;
        end
    end

    assign dutyOn = recoveryDuty25_r
        ? (dutyCnt_r < 16'(DUTY_PERIOD * DUTY_HIGH_PCT / 100))
        : (dutyCnt_r < 16'(DUTY_PERIOD * DUTY_LOW_PCT / 100));

    // ------------------------------------------------------------
    // driver enables
    // ------------------------------------------------------------
    assign supplyBlock = evS.overVolt | evS.underVolt
        | (cmd0_r[CMD_SUPPLY_LATCH] & (ovFlag_r | uvFlag_r));

    generate
        for (genvar d = 0; d < NUM_DRV; d++) begin : g_drv
            assign drvReq[d] = cmd0_r[CMD_DRV_LO + d]
                & (~cmd1_r[CMD1_PWM_EN_LO + outOfDrv(d)] | pwmS);
            assign drvAllow[d] = ~ocFlag_r[d] | (cmd1_r[CMD1_RECOVERY_LO + d] & dutyOn);
        end
        for (genvar b = 0; b < NUM_BRIDGE; b++) begin : g_bridge
            assign bridgeBoth[b] = cmd0_r[CMD_DRV_LO + 2 * b] & cmd0_r[CMD_DRV_LO + 2 * b + 1];
        end
    endgenerate

    always_comb begin
        drvOn_nxt = drvReq & drvAllow;
        // the cycle before the settle timer starts is blocked as well
        if (tsdFlag_r || supplyBlock || notReady_r || !enS || !enD_r) begin
            drvOn_nxt = '0;
        end
        for (int b = 0; b < NUM_BRIDGE; b++) begin
            if (bridgeBoth[b]) begin
                drvOn_nxt[2 * b] = 1'b0;
                drvOn_nxt[2 * b + 1] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            driverOn_r <= '0;
        end else begin
            driverOn_r <= drvOn_nxt;
        end
    end

    // ------------------------------------------------------------
    // serial output pin
    // ------------------------------------------------------------
    // test paths other than the faultFree summary are raw pins on purpose: they exist to observe them unfiltered
    always_comb begin
        unique case (bridgeBoth)
            3'b000: testBit = faultFree;
            3'b001: testBit = serial_in;
            3'b010: testBit = sclk;
            3'b011: testBit = intOsc;
            3'b100: testBit = pwmIn;
            default: testBit = faultFree;
        endcase
    end

    assign serialOut = testS ? testBit : linkBit;
    assign serialOutEn = ~frame_select_n | testS;

endmodule // adspi_top

//--- tb/adspi_host.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// host master, mode 0, lsb first
// ------------------------------------------------------------
module adspi_host (
    output logic sclk,
    output logic frame_select_n,
    output logic serial_in,
    input wire logic serialOut
);
    initial begin
        sclk = 1'b0;
        frame_select_n = 1'b1;
        serial_in = 1'b0;
    end
    // clock stands low between frames; released data line flips so no stale bit survives
    task automatic xfer(input logic [15:0] tx, input int nBits, output logic [15:0] rx);
        rx = 16'h0000;
        #10 frame_select_n = 1'b0;
        #200;
        for (int i = 0; i < nBits; i++) begin
            serial_in = tx[i % 16];
            #62.5;
            // sample just ahead of the rising edge, where the bit has stood half a period
            if (i < 16)
                rx[i] = serialOut;
            sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
        #62.5 frame_select_n = 1'b1;
        serial_in = ~serial_in;
        #400;
    endtask
    task automatic poll(output logic ff);
        frame_select_n = 1'b0;
        #200 ff = serialOut;
        frame_select_n = 1'b1;
        #400;
    endtask
endmodule // adspi_host

//--- tb/adspi_top_properties.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module adspi_top_check
    import adspi_pkg::*;
#(
    parameter int SETTLE_CNT = 10,
    parameter int DUTY_PERIOD = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic frame_select_n,
    input wire logic serialOutEn,
    input wire logic testModeDetect,
    input wire logic enableIn,
    input wire adspi_pkg::adspi_events_t eventsIn,
    input wire logic [adspi_pkg::NUM_DRV-1:0] driverOn_r,
    input wire logic [2:0] monitorSel_r,
    input wire logic recoveryDuty25_r,
    input wire logic ocThresholdLow_r,
    input wire logic testModeActive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // sync plus flag plus register leaves some slack, so judge from cycle six
    sequence sAllOff;
        ##6 (driverOn_r == 8'h00) [*4];
    endsequence
    a_out_enable: assert property (
        serialOutEn == (!frame_select_n || testModeActive)) else $error("output enable wrong");
    a_bridge_excl: assert property (
        !(driverOn_r[0] && driverOn_r[1]) && !(driverOn_r[2] && driverOn_r[3])
        && !(driverOn_r[4] && driverOn_r[5])) else $error("half bridge shoot through");
    a_settle_off: assert property (
        $rose(enableIn) |=> (driverOn_r == 8'h00) [*8]) else $error("driver on while settling");
    a_temp_off: assert property (
        $rose(eventsIn.overTemp) |-> sAllOff) else $error("overtemp left a driver on");
    a_supply_off: assert property (
        $rose(eventsIn.overVolt || eventsIn.underVolt) |-> sAllOff) else $error("supply trip ignored");
    a_oc_off: assert property (
        $rose(eventsIn.overCurrent[2]) |-> ##6 !driverOn_r[2] [*4]) else $error("over-current ignored");
    a_duty_forced: assert property (
        eventsIn.tempWarn [*8] |-> !recoveryDuty25_r) else $error("duty not forced low");
    a_cmd_quiet: assert property (
        frame_select_n [*8] |=> $stable(monitorSel_r)) else $error("command changed outside frame");
    a_test_enter: assert property (
        $rose(testModeDetect) |-> ##[1:4] testModeActive) else $error("test mode not entered");
    a_test_thresh: assert property (
        testModeActive [*3] |-> ocThresholdLow_r) else $error("threshold not reduced");
endmodule // adspi_top_check

bind adspi_top adspi_top_check #(.SETTLE_CNT(SETTLE_CNT), .DUTY_PERIOD(DUTY_PERIOD)) chk (
    .clk(clk), .rst_b(rst_b), .frame_select_n(frame_select_n), .serialOutEn(serialOutEn),
    .testModeDetect(testModeDetect), .enableIn(enableIn), .eventsIn(eventsIn),
    .driverOn_r(driverOn_r), .monitorSel_r(monitorSel_r), .recoveryDuty25_r(recoveryDuty25_r),
    .ocThresholdLow_r(ocThresholdLow_r), .testModeActive(testModeActive));

//--- tb/tb.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// top bench
// ------------------------------------------------------------
module tb;
    import adspi_pkg::*;
    localparam int SETTLE = 10;
    logic clk, rst_b, sclk, frame_select_n, serial_in, serialOut, serialOutEn, ff, tm, intOsc;
    logic testModeDetect, enableIn, pwmIn, testModeActive, recoveryDuty25_r, ocThresholdLow_r;
    logic [7:0] driverOn_r;
    logic [2:0] monitorSel_r;
    logic [15:0] cmd0, cmd1, rx, c;
    adspi_events_t eventsIn, fl, ev;
    int failures, n_compared;
    int seed = 32'h449ffd83;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    adspi_top #(.SETTLE_CNT(SETTLE), .DUTY_PERIOD(16)) dut (
        .clk(clk), .rst_b(rst_b), .sclk(sclk), .frame_select_n(frame_select_n),
        .serial_in(serial_in), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .testModeDetect(testModeDetect), .enableIn(enableIn), .pwmIn(pwmIn), .intOsc(intOsc),
        .eventsIn(eventsIn), .driverOn_r(driverOn_r), .monitorSel_r(monitorSel_r),
        .recoveryDuty25_r(recoveryDuty25_r), .ocThresholdLow_r(ocThresholdLow_r),
        .testModeActive(testModeActive));
    adspi_host host (.sclk(sclk), .frame_select_n(frame_select_n), .serial_in(serial_in),
        .serialOut(serialOut));
    function automatic logic [15:0] stat(input logic sel);
        logic [15:0] w0, w1;
        w0 = {1'b1, fl.overVolt, fl.underVolt, fl.overTemp, fl.tempWarn, 2'b00, fl.overCurrent, 1'b0};
        w1 = {7'h40, fl.openLoad, 1'b0};
        w0[0] = ~|{w0[14:1], w1[14:9], (cmd0[14] ? 8'h00 : w1[8:1])};
        return sel ? {w1[15:1], w0[0]} : w0;
    endfunction
    function automatic logic [7:0] drv(input logic [15:0] w);
        logic [7:0] d;
        d = w[8:1];
        for (int b = 0; b < 6; b += 2)
            if (d[b] && d[b+1])
                d[b+:2] = 2'b00;
        for (int i = 0; i < 8; i++)
            if (cmd1[9 + (i < 6 ? i / 2 : i - 3)] && !pwmIn)
                d[i] = 1'b0;
        d = d & ~fl.overCurrent;
        // latch bit picks between stored flag and live condition
        if (w[12] ? (fl.overVolt || fl.underVolt) : (eventsIn.overVolt || eventsIn.underVolt))
            d = 8'h00;
        return fl.overTemp ? 8'h00 : d;
    endfunction
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic frame(input logic [15:0] w, input int n);
        logic [15:0] e;
        e = stat(w[0]);
        host.xfer(w, n, rx);
        if (n == 16 && !tm)
            chk("status", rx, e);
        if (n == 16 && !w[0])
            cmd0 = w;
        if (n == 16 && w[0])
            cmd1 = w;
        if (n == 16 && w[15])
            fl = eventsIn;
        repeat (8) @(posedge clk);
        #5;
        chk("monitor", 16'(monitorSel_r), 16'(cmd0[11:9]));
        chk("drivers", 16'(driverOn_r), 16'(drv(cmd0)));
        chk("duty", 16'(recoveryDuty25_r), 16'(cmd0[13] && !fl.tempWarn));
    endtask
    task automatic setEv(input adspi_events_t e);
        @(posedge clk);
        eventsIn <= e;
        fl = fl | e;
        repeat (8) @(posedge clk);
    endtask
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #3000000;
        failures++;
        test_done;
    end
    initial begin
        rst_b = 1'b0;
        testModeDetect = 1'b0;
        enableIn = 1'b0;
        pwmIn = 1'b0;
        eventsIn = '0;
        fl = '0;
        cmd0 = 16'h0000;
        cmd1 = 16'h0000;
        intOsc = 1'b0;
        tm = 1'b0;
        failures = 0;
        n_compared = 0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        enableIn <= 1'b1;
        repeat (SETTLE + 10) @(posedge clk);
        frame(16'h0001, 16);
        for (int i = 0; i < 24; i++) begin
            c = 16'($random(seed));
            c[11:9] = c[11:9] % 5;
            c[15] = 1'b0;
            c[0] = 1'b0;
            // a short and a long frame must leave the command untouched
            frame(c, (i == 7) ? 15 : (i == 15) ? 17 : 16);
        end
        frame(16'h200a, 16);
        ev = '0;
        ev.overCurrent = 8'h04;
        ev.tempWarn = 1'b1;
        setEv(ev);
        frame(16'h200a, 16);
        setEv('0);
        frame(16'h200a, 16);
        frame(16'ha00a, 16);
        frame(16'h200a, 16);
        enableIn <= 1'b0;
        repeat (6) @(posedge clk);
        #5 chk("standby", 16'(driverOn_r), 16'h0000);
        @(posedge clk) enableIn <= 1'b1;
        repeat (SETTLE + 10) @(posedge clk);
        frame(16'h0201, 16);
        @(posedge clk) pwmIn <= 1'b1;
        frame(16'h200a, 16);
        @(posedge clk) pwmIn <= 1'b0;
        ev = '0;
        ev.openLoad = 8'h20;
        setEv(ev);
        frame(16'h0001, 16);
        host.poll(ff);
        chk("poll", 16'(ff), 16'h0000);
        frame(16'h4000, 16);
        host.poll(ff);
        chk("poll", 16'(ff), 16'h0001);
        setEv('0);
        frame(16'h8000, 16);
        for (int k = 0; k < 4; k++) begin
            c = {3'b000, k == 3, 12'h152};
            frame(c, 16);
            setEv(adspi_events_t'(20'h2 << (k % 2 + (k > 0))));
            frame(c, 16);
            setEv('0);
            frame(c, 16);
            frame(c | 16'h8000, 16);
        end
        tm = 1'b1;
        testModeDetect <= 1'b1;
        repeat (5) @(posedge clk);
        chk("test enable", 16'(serialOutEn), 16'h0001);
        frame(16'h0060, 16);
        for (int i = 0; i < 6; i++) begin
            pwmIn <= 1'($random(seed));
            repeat (4) @(posedge clk);
            chk("test pwm", 16'(serialOut), 16'(pwmIn));
        end
        frame(16'h001e, 16);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) intOsc <= 1'($random(seed));
            #5 chk("test osc", 16'(serialOut), 16'(intOsc));
        end
        frame(16'h0006, 16);
        chk("test data", 16'(serialOut), 16'(serial_in));
        frame(16'h0018, 16);
        chk("test clock", 16'(serialOut), 16'h0000);
        frame(16'h0000, 16);
        chk("test summary", 16'(serialOut), 16'h0001);
        test_done;
    end
endmodule // tb
